// file: icu_pkg.sv
// Constants shared by both ends and the core bus.
// Assumes a single 125 MHz system clock and an active-low asynchronous reset everywhere.
// How it works
// - 31 level requests raise a vectored request
// - Fixed priority, vector equals 10h plus line
// - Vector shows highest active enabled line
// - Acknowledge reads vector byte at FF FE00h
// - Vector byte: bits 5..0, top two zero
// - Vector held stable during acknowledge read
// - Core treats vector 10h as error
// - Core needs both global flags set
// - Requests gated by controller and peripheral enables
// - Nonmaskable status byte clears on reset, read
// - Falling pin edge makes trap when enabled
// - Control bits reset clear; reserved written zero
// - One-shot enable cleared by reset and event
// - One-shot set only while flag clear
// - Bit 1 reads pin level inverted, one while low
// - Lock enable holds until reset, overrides one-shot
// - First enable register resets FFFFh, bit0 ignored
// - Second enable register covers lines 16..31
// - First status shows raw lines 15..1
// - Second status shows raw lines 31..16
// - Pin synchronised before edge detection
package icu_pkg;
    // Request line count
    localparam int NUM_LINES = 32;

    // Register byte addresses on the core bus
    localparam logic [23:0] VECTOR_CODE_ADDR = 24'hff_fe00;
    localparam logic [23:0] NONMASKABLE_STATUS_ADDR = 24'hff_fe02;
    localparam logic [23:0] EXTERNAL_TRAP_CONTROL_ADDR = 24'hff_fe04;
    localparam logic [23:0] REQUEST_STATUS_LOW_ADDR = 24'hff_fe0a;
    localparam logic [23:0] REQUEST_STATUS_HIGH_ADDR = 24'hff_fe0c;
    localparam logic [23:0] SOURCE_ENABLE_LOW_ADDR = 24'hff_fe0e;
    localparam logic [23:0] SOURCE_ENABLE_HIGH_ADDR = 24'hff_fe10;

    // Vector encoding
    localparam logic [7:0] VECTOR_BASE = 8'h10;
    localparam logic [7:0] VECTOR_NONE = 8'h10;

    // Field positions
    localparam int OUTSIDE_FLAG_POS = 0;
    localparam int ONE_SHOT_POS = 0;
    localparam int PIN_LEVEL_POS = 1;
    localparam int LOCK_ENABLE_POS = 2;

    // Reset values
    localparam logic [15:0] SOURCE_ENABLE_RESET = 16'hffff;
    localparam logic [7:0] TRAP_CONTROL_RESET = 8'h00;

    // Host-side APB register offsets
    localparam logic [7:0] HOST_CTRL_OFS = 8'h00;
    localparam logic [7:0] HOST_ADDR_OFS = 8'h04;
    localparam logic [7:0] HOST_WDATA_OFS = 8'h08;
    localparam logic [7:0] HOST_CMD_OFS = 8'h0c;
    localparam logic [7:0] HOST_STATUS_OFS = 8'h10;
    localparam logic [7:0] HOST_RDATA_OFS = 8'h14;

    // Host status field positions
    localparam int ST_BUSY_POS = 0;
    localparam int ST_NMI_POS = 1;
    localparam int ST_VECERR_POS = 2;
    localparam int ST_IRQ_POS = 3;

    // Highest active line number, zero when none is active
    function automatic logic [4:0] top_line(input logic [31:0] lines);
        logic [4:0] idx;
        idx = 5'd0;
        for (int i = 1; i < 32; i++) begin
            if (lines[i]) begin
                idx = 5'(i);
            end
        end
        return idx;
    endfunction : top_line
endpackage : icu_pkg

// file: core_bus_if.sv
// Core bus between the two ends.
// Assumes both ends share one clock.
`timescale 1ns/10ps
`default_nettype none
interface core_bus_if;
    import icu_pkg::*;
    logic cbReq; // One-cycle access request from the core
    logic cbWr; // Access is a write
    logic [23:0] cbAddr; // Byte address
    logic [15:0] cbWdata; // Write data
    logic [15:0] cbRdata; // Read data, valid with cbAck
    logic cbAck; // One-cycle access completion
    logic ackCycle; // Core is in an interrupt acknowledge cycle
    logic intReq; // Maskable vectored request level
    logic nmiReq; // Nonmaskable one-cycle pulse

    modport ctrl (input cbReq, cbWr, cbAddr, cbWdata, ackCycle, output cbRdata, cbAck, intReq, nmiReq);
    modport core (output cbReq, cbWr, cbAddr, cbWdata, ackCycle, input cbRdata, cbAck, intReq, nmiReq);
endinterface : core_bus_if
`default_nettype wire

// file: pin_sync.sv
// Three-flop synchroniser with agreement filter and falling edge pulse.
// Assumes the pin idles high and is asynchronous to sys_clk.
`timescale 1ns/10ps
`default_nettype none
module pin_sync (
    input wire logic sys_clk, // System clock
    input wire logic rst_b, // Async reset, active low
    input wire logic pinIn, // Raw asynchronous pin
    output logic level, // Filtered level
    output logic fall // One-cycle pulse on filtered falling edge
);
    logic meta; // First stage, read only by second stage
    logic sync2; // Second stage
    logic sync3; // Third stage

    // Shift chain, idle high
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            meta <= 1'b1;
            sync2 <= 1'b1;
            sync3 <= 1'b1;
        end else begin
            meta <= pinIn;
            sync2 <= meta;
            sync3 <= sync2;
        end
    end

    // A change counts once stages two and three agree
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            level <= 1'b1;
            fall <= 1'b0;
        end else begin
            fall <= 1'b0;
            if (sync2 == sync3 && sync2 != level) begin
                level <= sync2;
                fall <= ~sync2;
            end
        end
    end
endmodule : pin_sync
`default_nettype wire

// file: request_controller.sv
// Request controller: 31 maskable lines, fixed-priority vector and external nonmaskable trap logic.
// Assumes request lines on sys_clk and an asynchronous active-low nonmaskable pin.
//
// Register access over the core bus was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module request_controller #(
    parameter int LINES = icu_pkg::NUM_LINES // Request lines including unused line 0
) (
    input wire logic sys_clk, // System clock, 125 MHz
    input wire logic rst_b, // Async reset, active low
    core_bus_if.ctrl bus, // Core bus and request outputs
    input wire logic [31:0] lineReq, // Peripheral request levels, bit 0 unused
    input wire logic nmiPin_b // External nonmaskable pin, active low
);
    import icu_pkg::*;

    // The encoder and registers serve exactly 32 lines
    if (LINES != 32) begin : g_bad_lines
        $error("request_controller serves exactly 32 request lines");
    end

    // Register state
    logic [15:0] sourceEnableLow; // Enables for lines 15..1, bit 0 ignored
    logic [15:0] sourceEnableHigh; // Enables for lines 31..16
    logic outsideRequestFlag; // Sticky external request flag
    logic oneShotEnable; // One-shot trap enable
    logic lockEnable; // Permanent trap enable
    logic [7:0] vectorCode; // Registered vector byte
    logic [31:0] lineActive; // Lines seen this cycle, line 0 forced off
    logic [31:0] lineGated; // Active and enabled lines
    logic [7:0] next_vector; // Freshly encoded vector
    logic pinLevel; // Filtered pin level, high idle
    logic pinFall; // Filtered falling edge
    logic nmiEvent; // Enabled falling edge
    logic rdHit; // Read of any register this cycle
    logic wrHit; // Write of any register this cycle
    logic [15:0] next_rdata; // Read data mux

    // Pin synchroniser
    pin_sync u_pin_sync (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .pinIn(nmiPin_b),
        .level(pinLevel),
        .fall(pinFall)
    );

    // Raw lines; line 0 has no source
    assign lineActive = {lineReq[31:1], 1'b0};

    // Gating by the controller enables; peripheral enables act before lineReq
    assign lineGated = lineActive & {sourceEnableHigh, sourceEnableLow[15:1], 1'b0};

    // Fixed linear priority, highest line wins, base 10h
    assign next_vector = VECTOR_BASE + {3'b000, top_line(lineGated)};

    // Either enable arms the trap
    assign nmiEvent = pinFall && (oneShotEnable || lockEnable);

    // Bus strobes
    assign rdHit = bus.cbReq && !bus.cbWr;
    assign wrHit = bus.cbReq && bus.cbWr;

    // Vector register: tracks priority result, frozen during an acknowledge
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            vectorCode <= VECTOR_NONE;
        end else if (!bus.ackCycle) begin
            // Top two bits read zero
            vectorCode <= {2'b00, next_vector[5:0]};
        end
    end

    // Maskable request level to the core
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            bus.intReq <= 1'b0;
        end else begin
            bus.intReq <= |lineGated;
        end
    end

    // Nonmaskable pulse to the core
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            bus.nmiReq <= 1'b0;
        end else begin
            bus.nmiReq <= nmiEvent;
        end
    end

    // Source enable registers, both reset to all ones
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sourceEnableLow <= SOURCE_ENABLE_RESET;
            sourceEnableHigh <= SOURCE_ENABLE_RESET;
        end else if (wrHit) begin
            if (bus.cbAddr == SOURCE_ENABLE_LOW_ADDR) begin
                sourceEnableLow <= bus.cbWdata;
            end
            if (bus.cbAddr == SOURCE_ENABLE_HIGH_ADDR) begin
                sourceEnableHigh <= bus.cbWdata;
            end
        end
    end

    // External request flag: event sets, status read clears; set wins
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            outsideRequestFlag <= 1'b0;
        end else if (nmiEvent) begin
            outsideRequestFlag <= 1'b1;
        end else if (rdHit && bus.cbAddr == NONMASKABLE_STATUS_ADDR) begin
            outsideRequestFlag <= 1'b0;
        end
    end

    // One-shot enable: hardware clear on event beats any write
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            oneShotEnable <= TRAP_CONTROL_RESET[ONE_SHOT_POS];
        end else if (nmiEvent) begin
            oneShotEnable <= 1'b0;
        end else if (wrHit && bus.cbAddr == EXTERNAL_TRAP_CONTROL_ADDR) begin
            if (!bus.cbWdata[ONE_SHOT_POS]) begin
                oneShotEnable <= 1'b0;
            end else if (!outsideRequestFlag) begin
                oneShotEnable <= 1'b1;
            end
        end
    end

    // Lock enable: can only be set; only reset clears it
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            lockEnable <= TRAP_CONTROL_RESET[LOCK_ENABLE_POS];
        end else if (wrHit && bus.cbAddr == EXTERNAL_TRAP_CONTROL_ADDR
                     && bus.cbWdata[LOCK_ENABLE_POS]) begin
            lockEnable <= 1'b1;
        end
    end

    // Read data selection; unmapped addresses read zero
    always_comb begin
        next_rdata = 16'h0000;
        unique case (bus.cbAddr)
            VECTOR_CODE_ADDR: begin
                next_rdata = {8'h00, vectorCode};
            end
            NONMASKABLE_STATUS_ADDR: begin
                next_rdata[OUTSIDE_FLAG_POS] = outsideRequestFlag;
            end
            EXTERNAL_TRAP_CONTROL_ADDR: begin
                // Reserved bits 7..3 read zero; pin bit reads asserted as one
                next_rdata[ONE_SHOT_POS] = oneShotEnable;
                next_rdata[PIN_LEVEL_POS] = ~pinLevel;
                next_rdata[LOCK_ENABLE_POS] = lockEnable;
            end
            REQUEST_STATUS_LOW_ADDR: begin
                next_rdata = lineActive[15:0];
            end
            REQUEST_STATUS_HIGH_ADDR: begin
                next_rdata = lineActive[31:16];
            end
            SOURCE_ENABLE_LOW_ADDR: begin
                next_rdata = sourceEnableLow;
            end
            SOURCE_ENABLE_HIGH_ADDR: begin
                next_rdata = sourceEnableHigh;
            end
            default: begin
                next_rdata = 16'h0000;
            end
        endcase
    end

    // Answer one cycle after each request
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            bus.cbAck <= 1'b0;
            bus.cbRdata <= 16'h0000;
        end else begin
            bus.cbAck <= bus.cbReq;
            if (rdHit) begin
                bus.cbRdata <= next_rdata;
            end
        end
    end
endmodule : request_controller
`default_nettype wire

// file: core_side.sv
// Core side of the core bus: APB-driven accesses and acknowledges.
// Assumes an APB master on sys_clk and the controller across the interface.
`timescale 1ns/10ps
`default_nettype none
module core_side (
    input wire logic sys_clk, // System clock
    input wire logic rst_b, // Async reset, active low
    core_bus_if.core bus, // Core bus toward the controller
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB write
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr // APB error, always low
);
    import icu_pkg::*;

    typedef enum logic [1:0] {
        IDLE = 2'b00,
        ISSUE = 2'b01,
        WAIT = 2'b11
    } bus_state_e;

    bus_state_e state; // Core bus sequencer
    logic globalOn; // Global enable flag of the state word
    logic maskableOn; // Maskable enable flag of the state word
    logic [23:0] accAddr; // Software access address
    logic [15:0] accWdata; // Software write data
    logic [15:0] accRdata; // Last software read data
    logic nmiSeen; // Sticky nonmaskable pulse seen
    logic vecErr; // Sticky vector 10h error
    logic [7:0] lastVector; // Last acknowledged vector
    logic isAck; // Current access is an acknowledge
    logic apbWr; // APB write taken this edge
    logic swStart; // Software command accepted
    logic takeIrq; // Acknowledge may start

    assign apbWr = psel && penable && pready && pwrite;
    assign swStart = apbWr && paddr == HOST_CMD_OFS && |pwdata[1:0] && state == IDLE;
    assign takeIrq = bus.intReq && globalOn && maskableOn && state == IDLE && !swStart;

    // APB ready: one wait state per access
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && penable && !pready;
        end
    end

    // Software-written registers
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            globalOn <= 1'b0;
            maskableOn <= 1'b0;
            accAddr <= 24'h00_0000;
            accWdata <= 16'h0000;
        end else if (apbWr) begin
            if (paddr == HOST_CTRL_OFS) begin
                globalOn <= pwdata[0];
                maskableOn <= pwdata[1];
            end
            if (paddr == HOST_ADDR_OFS) begin
                accAddr <= pwdata[23:0];
            end
            if (paddr == HOST_WDATA_OFS) begin
                accWdata <= pwdata[15:0];
            end
        end
    end

    // Core bus sequencer
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= IDLE;
            isAck <= 1'b0;
            bus.cbReq <= 1'b0;
            bus.cbWr <= 1'b0;
            bus.cbAddr <= 24'h00_0000;
            bus.cbWdata <= 16'h0000;
            bus.ackCycle <= 1'b0;
        end else begin
            unique case (state)
                IDLE: begin
                    if (swStart) begin
                        state <= ISSUE;
                        isAck <= 1'b0;
                        bus.cbReq <= 1'b1;
                        bus.cbWr <= pwdata[1];
                        bus.cbAddr <= accAddr;
                        bus.cbWdata <= accWdata;
                    end else if (takeIrq) begin
                        state <= ISSUE;
                        isAck <= 1'b1;
                        bus.cbReq <= 1'b1;
                        bus.cbWr <= 1'b0;
                        bus.cbAddr <= VECTOR_CODE_ADDR;
                        bus.ackCycle <= 1'b1;
                    end
                end
                ISSUE: begin
                    bus.cbReq <= 1'b0;
                    state <= WAIT;
                end
                WAIT: begin
                    if (bus.cbAck) begin
                        bus.ackCycle <= 1'b0;
                        state <= IDLE;
                    end
                end
            endcase
        end
    end

    // Answer capture and sticky flags; set beats clear
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            accRdata <= 16'h0000;
            lastVector <= 8'h00;
            vecErr <= 1'b0;
            nmiSeen <= 1'b0;
        end else begin
            if (state == WAIT && bus.cbAck) begin
                if (isAck) begin
                    lastVector <= bus.cbRdata[7:0];
                end else if (!bus.cbWr) begin
                    accRdata <= bus.cbRdata;
                end
            end
            if (state == WAIT && bus.cbAck && isAck && bus.cbRdata[7:0] == VECTOR_NONE) begin
                vecErr <= 1'b1;
            end else if (apbWr && paddr == HOST_STATUS_OFS && pwdata[ST_VECERR_POS]) begin
                vecErr <= 1'b0;
            end
            if (bus.nmiReq) begin
                nmiSeen <= 1'b1;
            end else if (apbWr && paddr == HOST_STATUS_OFS && pwdata[ST_NMI_POS]) begin
                nmiSeen <= 1'b0;
            end
        end
    end

    // APB read data, registered at the setup cycle
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable) begin
            unique case (paddr)
                HOST_CTRL_OFS: prdata <= {30'h0000_0000, maskableOn, globalOn};
                HOST_ADDR_OFS: prdata <= {8'h00, accAddr};
                HOST_WDATA_OFS: prdata <= {16'h0000, accWdata};
                HOST_STATUS_OFS: prdata <= {16'h0000, lastVector, 4'h0, bus.intReq, vecErr, nmiSeen,
                                            state != IDLE};
                HOST_RDATA_OFS: prdata <= {16'h0000, accRdata};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule : core_side
`default_nettype wire

// file: icu_checker.sv
// Concurrent checks on the core bus between both ends.
// Assumes one clock, sys_clk, and an asynchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module icu_checker (
    input wire logic sys_clk, // System clock
    input wire logic rst_b, // Reset, active low
    input wire logic cbReq, // Access request
    input wire logic cbWr, // Access is a write
    input wire logic [23:0] cbAddr, // Byte address
    input wire logic [15:0] cbRdata, // Read data
    input wire logic cbAck, // Access done
    input wire logic ackCycle, // Acknowledge in progress
    input wire logic nmiReq // Nonmaskable pulse
);
    import icu_pkg::*;
    logic [23:0] rdAddr; // Address of the read being answered
    logic seen; // Nonmaskable event not yet read back
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // Address being read; writes map to an unused one
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdAddr <= 24'h00_0000;
        end else if (cbReq) begin
            rdAddr <= cbWr ? 24'hff_ffff : cbAddr;
        end
    end
    // Event pending until a status read
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            seen <= 1'b0;
        end else if (cbReq && !cbWr && cbAddr == NONMASKABLE_STATUS_ADDR) begin
            seen <= 1'b0;
        end else if (nmiReq) begin
            seen <= 1'b1;
        end
    end
    a_ack_next_cycle: assert property (cbReq |=> cbAck) else $error("no answer");
    a_ack_has_cause: assert property (cbAck |-> $past(cbReq)) else $error("stray answer");
    a_vector_format: assert property (cbAck && rdAddr == VECTOR_CODE_ADDR |->
        cbRdata[15:6] == 10'h000 && cbRdata[5:0] inside {[6'h10:6'h2f]}) else $error("vector out of range");
    a_ack_vector_valid: assert property (ackCycle && cbAck |-> cbRdata[7:0] inside {[8'h10:8'h2f]})
        else $error("bad acknowledge vector");
    a_status_bit_zero: assert property (cbAck && rdAddr == REQUEST_STATUS_LOW_ADDR |-> !cbRdata[0])
        else $error("status bit 0 set");
    a_nmi_stat_byte: assert property (cbAck && rdAddr == NONMASKABLE_STATUS_ADDR |-> cbRdata[15:1] == 15'h0000)
        else $error("status upper bits set");
    a_trap_reserved_zero: assert property (cbAck && rdAddr == EXTERNAL_TRAP_CONTROL_ADDR |-> cbRdata[15:3] == 13'h0000)
        else $error("reserved bits set");
    a_nmi_one_pulse: assert property (nmiReq |=> !nmiReq) else $error("pulse too long");
    a_nmi_flag_read: assert property (cbReq && !cbWr && cbAddr == NONMASKABLE_STATUS_ADDR && seen |=>
        cbAck && cbRdata[0]) else $error("flag missing");
endmodule : icu_checker
`default_nettype wire

// file: testbench.sv
// Self-checking bench: APB master, core side and request controller.
// Assumes core accesses are polled through the busy bit.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import icu_pkg::*;
    logic sys_clk, rst_b, nmiPin_b, psel, penable, pwrite, pready, pslverr; // Clock, reset, pin, APB
    logic [31:0] lineReq, pwdata, prdata, lin, en, r; // Requests, APB data, scratch
    logic [7:0] paddr; // APB address
    logic [15:0] r16; // Core read data
    logic [31:0] seed = 32'h0000_9ed7; // Random state
    int failCount = 0; // Mismatches
    int checks = 0; // Comparisons
    int n; // Line under test
    core_bus_if bus();
    request_controller #(.LINES(NUM_LINES)) i_request_controller (.sys_clk(sys_clk), .rst_b(rst_b), .bus(bus),
        .lineReq(lineReq), .nmiPin_b(nmiPin_b));
    core_side i_core_side (.sys_clk(sys_clk), .rst_b(rst_b), .bus(bus), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    icu_checker i_icu_checker (.sys_clk(sys_clk), .rst_b(rst_b), .cbReq(bus.cbReq), .cbWr(bus.cbWr),
        .cbAddr(bus.cbAddr), .cbRdata(bus.cbRdata), .cbAck(bus.cbAck), .ackCycle(bus.ackCycle), .nmiReq(bus.nmiReq));
    // Free-running 125 MHz clock
    always #4 sys_clk = ~sys_clk;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    // Expected vector; line 0 never counts
    function automatic logic [7:0] expVec(input logic [31:0] l, input logic [31:0] e);
        logic [7:0] v;
        v = VECTOR_BASE;
        for (int i = 1; i < 32; i++) begin
            if (l[i] && e[i]) begin
                v = VECTOR_BASE + 8'(i);
            end
        end
        return v;
    endfunction : expVec
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        checks++;
        if (s !== e) begin
            failCount++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(negedge sys_clk); while (pready !== 1'b1);
        @(posedge sys_clk);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // One core bus access via the host registers
    task automatic cb(input logic w, input logic [23:0] a, input logic [15:0] d, output logic [15:0] q);
        logic [31:0] t;
        apb(1'b1, HOST_ADDR_OFS, {8'h00, a}, t);
        apb(1'b1, HOST_WDATA_OFS, {16'h0000, d}, t);
        apb(1'b1, HOST_CMD_OFS, w ? 32'h0000_0002 : 32'h0000_0001, t);
        t = 32'h0000_0001;
        while (t[ST_BUSY_POS] !== 1'b0) apb(1'b0, HOST_STATUS_OFS, 32'h0000_0000, t);
        apb(1'b0, HOST_RDATA_OFS, 32'h0000_0000, t);
        q = t[15:0];
    endtask : cb
    task automatic rdChk(input string nm, input logic [23:0] a, input logic [15:0] e);
        cb(1'b0, a, 16'h0000, r16);
        chk(nm, 32'(e), 32'(r16));
    endtask : rdChk
    // Low pulse, long enough for the filter
    task automatic pulsePin();
        nmiPin_b <= 1'b0;
        repeat (12) @(posedge sys_clk);
        nmiPin_b <= 1'b1;
        repeat (12) @(posedge sys_clk);
    endtask : pulsePin
    task automatic end_sim();
        $display("checks %0d failCount %0d", checks, failCount);
        if (failCount == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_sim
    // Watchdog against a hung handshake
    initial begin
        repeat (60000) @(posedge sys_clk);
        failCount++;
        end_sim();
    end
    // Main sequence
    initial begin
        sys_clk = 1'b0;
        rst_b = 1'b0;
        lineReq = 32'h0000_0000;
        nmiPin_b = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (4) @(posedge sys_clk);
        rst_b <= 1'b1;
        rdChk("enLowRst", SOURCE_ENABLE_LOW_ADDR, 16'hffff);
        rdChk("enHighRst", SOURCE_ENABLE_HIGH_ADDR, 16'hffff);
        rdChk("trapRst", EXTERNAL_TRAP_CONTROL_ADDR, 16'h0000);
        rdChk("nmiRst", NONMASKABLE_STATUS_ADDR, 16'h0000);
        rdChk("unmapped", 24'hff_fe06, 16'h0000);
        apb(1'b0, 8'h40, 32'h0000_0000, r);
        chk("apbUnmapped", 32'h0000_0000, r);
        chk("pslverr", 32'h0000_0000, 32'(pslverr));
        // Random lines and enables; all-clear and line 0 first
        for (int k = 0; k < 24; k++) begin
            lin = (k < 2) ? 32'(k) : rnd() & rnd();
            en = rnd();
            lineReq <= lin;
            cb(1'b1, SOURCE_ENABLE_LOW_ADDR, en[15:0], r16);
            cb(1'b1, SOURCE_ENABLE_HIGH_ADDR, en[31:16], r16);
            rdChk("statLow", REQUEST_STATUS_LOW_ADDR, {lin[15:1], 1'b0});
            rdChk("statHigh", REQUEST_STATUS_HIGH_ADDR, lin[31:16]);
            rdChk("enHigh", SOURCE_ENABLE_HIGH_ADDR, en[31:16]);
            rdChk("vector", VECTOR_CODE_ADDR, {8'h00, expVec(lin, en)});
            apb(1'b0, HOST_STATUS_OFS, 32'h0000_0000, r);
            chk("intReq", 32'(|(lin & en & 32'hffff_fffe)), 32'(r[ST_IRQ_POS]));
        end
        lineReq <= 32'h0000_0000;
        cb(1'b1, REQUEST_STATUS_LOW_ADDR, 16'hffff, r16);
        rdChk("statRo", REQUEST_STATUS_LOW_ADDR, 16'h0000);
        cb(1'b1, SOURCE_ENABLE_LOW_ADDR, 16'hffff, r16);
        cb(1'b1, SOURCE_ENABLE_HIGH_ADDR, 16'hffff, r16);
        // Acknowledge cycles for the lowest, highest and a random line
        for (int k = 0; k < 3; k++) begin
            n = (k == 0) ? 1 : (k == 1) ? 31 : int'(rnd() % 30) + 1;
            lineReq <= 32'h0000_0001 << n;
            apb(1'b1, HOST_CTRL_OFS, 32'h0000_0003, r);
            repeat (12) @(posedge sys_clk);
            apb(1'b1, HOST_CTRL_OFS, 32'h0000_0000, r);
            repeat (6) @(posedge sys_clk);
            apb(1'b0, HOST_STATUS_OFS, 32'h0000_0000, r);
            chk("ackVector", 32'(VECTOR_BASE + 8'(n)), 32'(r[15:8]));
        end
        lineReq <= 32'h0000_0000;
        // Nonmaskable trap: disabled, one-shot, then locked
        pulsePin();
        rdChk("nmiOff", NONMASKABLE_STATUS_ADDR, 16'h0000);
        cb(1'b1, EXTERNAL_TRAP_CONTROL_ADDR, 16'h0001, r16);
        nmiPin_b <= 1'b0;
        repeat (12) @(posedge sys_clk);
        rdChk("trapFired", EXTERNAL_TRAP_CONTROL_ADDR, 16'h0002);
        cb(1'b1, EXTERNAL_TRAP_CONTROL_ADDR, 16'h0001, r16);
        rdChk("trapHeld", EXTERNAL_TRAP_CONTROL_ADDR, 16'h0002);
        nmiPin_b <= 1'b1;
        repeat (12) @(posedge sys_clk);
        rdChk("nmiSet", NONMASKABLE_STATUS_ADDR, 16'h0001);
        rdChk("nmiClr", NONMASKABLE_STATUS_ADDR, 16'h0000);
        cb(1'b1, EXTERNAL_TRAP_CONTROL_ADDR, 16'h0001, r16);
        rdChk("trapArm", EXTERNAL_TRAP_CONTROL_ADDR, 16'h0001);
        cb(1'b1, EXTERNAL_TRAP_CONTROL_ADDR, 16'h0004, r16);
        cb(1'b1, EXTERNAL_TRAP_CONTROL_ADDR, 16'h0000, r16);
        rdChk("lock", EXTERNAL_TRAP_CONTROL_ADDR, 16'h0004);
        repeat (2) begin
            pulsePin();
            rdChk("nmiLock", NONMASKABLE_STATUS_ADDR, 16'h0001);
        end
        end_sim();
    end
endmodule : testbench
`default_nettype wire
